/* File: bench/rpc_radio_model.sv */
// Stand-in for the radio state machine and its datapaths
module rpc_radio_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Commands from the bench
    input wire rpc_pkg::rpc_radio_t i_state,
    input wire rpc_pkg::rpc_act_t i_act,
    input wire rpc_pkg::rpc_frame_t i_frame,
    // Control from the block
    input wire logic i_abort_relisten,
    // Radio view seen by the block
    output rpc_pkg::rpc_radio_t o_radio,
    output rpc_pkg::rpc_act_t o_act,
    output rpc_pkg::rpc_frame_t o_frame,
    output logic [7:0] o_relisten_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // Everything changes just after an edge; frame fields hold junk outside
    // the valid cycle, so a stale value can never pass for a fresh frame
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_radio <= rpc_pkg::RPC_ST_OFF;
            o_act <= '0;
            o_frame <= '0;
            o_relisten_cnt <= 8'h00;
        end else begin
            o_radio <= i_state;
            o_act <= i_act;
            o_frame <= i_frame.valid ? i_frame : {1'b0, ~o_frame[23:0]};
            // Each abort starts a fresh listen period
            if (i_abort_relisten) begin
                o_relisten_cnt <= o_relisten_cnt + 8'h01;
            end
        end
    end
endmodule // rpc_radio_model

/* File: bench/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CAL = 4;
    logic i_clk, i_resetn, i_wr, i_rd;
    logic [7:0] i_addr, i_wdata, o_rdata, relisten_cnt, v, w;
    rpc_pkg::rpc_radio_t st, radio_s;
    rpc_pkg::rpc_act_t act_cmd, act, a;
    rpc_pkg::rpc_frame_t frm_cmd, frm, f;
    logic o_power_save, o_abort_relisten, o_desense_on, o_smart_rx_on, o_synth_saving;
    logic o_deep_desense;
    logic [1:0] o_smart_rx_level;
    logic [3:0] o_tx_power;
    int seed = 45960;
    int n_mismatch = 0;
    int checked = 0;
    int i, k;

    rpc_ctrl #(.CAL_CYCLES(CAL)) dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_wr(i_wr),
        .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .i_radio(radio_s), .i_act(act), .i_frame(frm), .o_power_save(o_power_save),
        .o_abort_relisten(o_abort_relisten), .o_desense_on(o_desense_on),
        .o_deep_desense(o_deep_desense),
        .o_smart_rx_on(o_smart_rx_on), .o_smart_rx_level(o_smart_rx_level),
        .o_synth_saving(o_synth_saving), .o_tx_power(o_tx_power));
    rpc_radio_model radio_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_state(st),
        .i_act(act_cmd), .i_frame(frm_cmd), .i_abort_relisten(o_abort_relisten),
        .o_radio(radio_s), .o_act(act), .o_frame(frm), .o_relisten_cnt(relisten_cnt));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Every driver starts on a fresh edge, so no signal is assigned twice at once
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= ad;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= ad;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
    endtask
    // Levels stay, pulses and the frame last one cycle
    task automatic radio(input rpc_pkg::rpc_radio_t s, input rpc_pkg::rpc_act_t lv,
                         input rpc_pkg::rpc_act_t pu, input rpc_pkg::rpc_frame_t fr);
        @(posedge i_clk);
        st <= s;
        act_cmd <= lv | pu;
        frm_cmd <= fr;
        @(posedge i_clk);
        act_cmd <= lv;
        frm_cmd <= '0;
    endtask
    // Sample away from the edge, after the model and the block have both moved
    task automatic look(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask
    // Ceiling 3 configured; between the thresholds one code per 4 dBm above -77
    function automatic logic [7:0] exp_pwr(input logic signed [7:0] ed, input logic [7:0] lq,
                                           input logic dup);
        if (dup || lq <= 8'hE0 || ed <= -77) begin
            return 8'h03;
        end
        if (ed <= -45) begin
            return 8'(3 + (ed + 77) / 4 + 1);
        end
        return 8'h0F;
    endfunction

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // Tests need well under 2000 cycles; ten times that means a hang
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        test_done();
    end
    initial begin
        i_resetn = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        st = rpc_pkg::RPC_ST_OFF;
        act_cmd = '0;
        frm_cmd = '0;
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(8'h16, v);
        check(v, 8'hC1);
        check({o_smart_rx_level, o_smart_rx_on, o_desense_on, o_synth_saving, o_deep_desense,
               2'h0}, 8'hC0);
        rd(8'h05, v);
        check(v, 8'h00);
        rd(8'h3F, v);
        check(v, 8'h00);
        $display("test reset done");
        // Each power-save cause alone, then released; the last two must not save
        for (i = 0; i < 7; i++) begin
            a = '0;
            case (i)
                0: a.backoff = 1'b1;
                1: a.ack_wait = 1'b1;
                2: a.ack_pending = 1'b1;
                3, 4: a.buf_protect = 1'b1;
                5: a.backoff = 1'b1;
                default: a = '0;
            endcase
            a.cca_ed = (i == 5);
            radio(i < 2 || i == 5 ? rpc_pkg::RPC_ST_ARET : i == 3 || i == 6 ?
                  rpc_pkg::RPC_ST_RX : rpc_pkg::RPC_ST_AUTO_ACK_RECEIVE_STATE, a, '0, '0);
            look(1);
            check(8'(o_power_save), 8'(i < 5));
            radio(st, '0, '0, '0);
            look(1);
            check(8'(o_power_save), 8'h00);
        end
        $display("test power save done");
        // PAN mismatch: aborts only with both aux bits and no promiscuous mode
        wr(8'h16, 8'h03);
        for (i = 0; i < 3; i++) begin
            wr(8'h17, i == 0 ? 8'h03 : i == 1 ? 8'h01 : 8'h07);
            a = '0;
            a.pan_fail = 1'b1;
            f = '0;
            f.valid = 1'b1;
            radio(rpc_pkg::RPC_ST_AUTO_ACK_RECEIVE_STATE, '0, a, f);
            look(1);
            check(8'(o_abort_relisten), 8'(i == 0));
        end
        check(relisten_cnt, 8'h01);
        // PAN match, address fail: sleep to frame end, or to leaving with an ack asked
        wr(8'h17, 8'h03);
        for (i = 0; i < 2; i++) begin
            a = '0;
            a.addr_fail = 1'b1;
            a.ack_req = (i == 1);
            radio(rpc_pkg::RPC_ST_AUTO_ACK_RECEIVE_STATE, '0, a, f);
            look(2);
            check(8'(o_power_save), 8'h01);
            a = '0;
            a.frame_end = 1'b1;
            a.ack_req = (i == 1);
            radio(rpc_pkg::RPC_ST_AUTO_ACK_RECEIVE_STATE, '0, a, '0);
            look(1);
            check(8'(o_power_save), 8'(i));
            radio(rpc_pkg::RPC_ST_RX, '0, '0, '0);
            look(1);
            check(8'(o_power_save), 8'h00);
        end
        $display("test pan match done");
        // Ack power from energy and quality; pass 3 repeats the sequence number
        wr(8'h16, 8'h05);
        wr(8'h05, 8'h03);
        for (i = 0; i < 10; i++) begin
            f = '0;
            f.valid = 1'b1;
            f.seq = (i == 3) ? 8'h12 : 8'(i + 16);
            f.ed_dbm = i == 1 ? -8'sd80 : i == 4 ? -8'sd60 : i < 4 ? -8'sd40 :
                -$signed({3'h0, 5'($random(seed))});
            f.lqi = i == 2 ? 8'hE0 : i < 4 ? 8'hF0 : 8'hE1 + 8'($random(seed) & 15);
            radio(rpc_pkg::RPC_ST_AUTO_ACK_RECEIVE_STATE, '0, '0, f);
            // Power is latched with the frame, then shown a cycle later
            look(2);
            check(8'(o_tx_power), exp_pwr(f.ed_dbm, f.lqi, i == 3));
        end
        a = '0;
        a.tx_start = 1'b1;
        radio(rpc_pkg::RPC_ST_AUTO_ACK_RECEIVE_STATE, '0, a, '0);
        rd(8'h05, v);
        check(v, 8'h0F);
        // Retry: first attempt at configured power, after a failure +4 dBm
        a.tx_start = 1'b0;
        a.aret_start = 1'b1;
        radio(rpc_pkg::RPC_ST_ARET, '0, a, '0);
        look(1);
        check(8'(o_tx_power), 8'h03);
        a.aret_start = 1'b0;
        a.tx_fail = 1'b1;
        radio(rpc_pkg::RPC_ST_ARET, '0, a, '0);
        look(2);
        check(8'(o_tx_power), 8'h00);
        $display("test tx power done");
        // Synthesizer saving: calibration first, a wake, then saving again
        wr(8'h16, 8'h09);
        for (i = 0; i < 2; i++) begin
            a = '0;
            radio(i == 0 ? rpc_pkg::RPC_ST_SYNTH_ON : rpc_pkg::RPC_ST_SYNTH_ON, a, '0, '0);
            k = 0;
            while (o_synth_saving !== 1'b1 && k < 40) begin
                @(negedge i_clk);
                k = k + 1;
            end
            check(8'(k), 8'(i == 0 ? CAL + 2 : 2));
            a.synth_wake = 1'b1;
            radio(rpc_pkg::RPC_ST_SYNTH_ON, a, '0, '0);
            look(1);
            check(8'(o_synth_saving), 8'h00);
        end
        wr(8'h16, 8'hC1);
        radio(rpc_pkg::RPC_ST_OFF, '0, '0, '0);
        radio(rpc_pkg::RPC_ST_SYNTH_ON, '0, '0, '0);
        look(CAL + 4);
        check(8'(o_synth_saving), 8'h00);
        $display("test synth saving done");
        // Random control values; scans must drop desense and smart receive
        wr(8'h15, 8'h08);
        for (i = 0; i < 8; i++) begin
            w = i == 0 ? 8'hFF : i == 1 ? 8'h01 : 8'($random(seed)) | 8'h01;
            wr(8'h16, w);
            rd(8'h16, v);
            check(v, w);
            radio(rpc_pkg::RPC_ST_RX, '0, '0, '0);
            look(1);
            check({o_smart_rx_level, o_smart_rx_on, o_desense_on, o_deep_desense, 3'h0},
                  {w[7:4], w[4], 3'h0});
            a = '0;
            a.cca_ed = 1'b1;
            radio(rpc_pkg::RPC_ST_RX, a, '0, '0);
            look(1);
            check({5'h00, o_deep_desense, o_smart_rx_on, o_desense_on}, 8'h00);
            radio(rpc_pkg::RPC_ST_RX, '0, '0, '0);
        end
        $display("test control register done");
        test_done();
    end
endmodule // testbench

/* File: rtl/rpc_ack_power.sv */
// Acknowledgement power selection from received energy and link quality
`include "rpc_map.svh"
module rpc_ack_power (
    // Frame quality and configuration
    input wire logic signed [7:0] i_ed_dbm,
    input wire logic [7:0] i_lqi,
    input wire logic i_dup_seq,
    input wire logic i_enable,
    input wire logic [3:0] i_ceiling,
    // Chosen power code
    output logic [3:0] o_power
);
    // Linear step between ceiling and floor across -77..-45 dBm
    logic signed [8:0] span;
    logic [3:0] step;
    always_comb begin
        span = 9'(i_ed_dbm) - 9'(`RPC_ED_REDUCE);
        step = 4'(span[8:1] >> 1);
        o_power = i_ceiling;
        if (i_enable && !i_dup_seq && i_lqi > `RPC_LQI_MIN) begin // R06
            if (i_ed_dbm > `RPC_ED_FLOOR) begin
                o_power = `RPC_PWR_MIN; // R04
            end else if (i_ed_dbm > `RPC_ED_REDUCE) begin
                o_power = ({1'b0, i_ceiling} + {1'b0, step} + 5'h01 > 5'h0F) ?
                    `RPC_PWR_MIN : 4'(i_ceiling + step + 4'h1); // R03
            end
        end
    end
endmodule // rpc_ack_power

/* File: rtl/rpc_ctrl.sv */
// What this block does
// R01 - Desense plus threshold 0x08 limits sensitivity near -80 dBm for lower current.
// R02 - Desense is suspended during any CCA or energy scan.
// R03 - Auto power lowers ack power for energy above -77 dBm, LQI above 224.
// R04 - Ack power floor -17 dBm above -45 dBm; ceiling is the power field.
// R05 - Power field reads back the power used for the last sent frame.
// R06 - A repeated sequence number disables ack power reduction.
// R07 - After a failed reduced-power first attempt, retries use +4 dBm.
// R08 - PAN mismatch with PAN match on aborts reception and relistens.
// R09 - PAN match but address fail sleeps for frame and requested ack.
// R10 - PAN match acts only with short ack time and reserved type filter.
// R11 - Promiscuous mode disables PAN match recognition.
// R12 - Sleep while frame buffer protection holds a frame in receive states.
// R13 - Sleep during the random backoff after a retry transaction starts.
// R14 - Sleep awaiting an ack in retry transmit, or before sending one.
// R15 - Host uses smart level 0 or short ack time for fast-turnaround peers.
// R16 - Bits 7:6 pick smart receive level; 0 minimum, 3 maximum at reset.
// R17 - Bit 5 enables smart receive power reduction; cleared at reset.
// R18 - Bit 4 enables reduced-sensitivity receive mode; cleared at reset.
// R19 - Bit 3 enables synthesizer saving in synth-on and retry-on states.
// R20 - Bit 2 enables automatic transmit power handling; cleared at reset.
// R21 - Bit 1 enables PAN match recognition; cleared at reset.
// R22 - Host always writes one to reserved bit 0, which resets to one.
// R23 - Synth saving calibrates on entry, then saves; activity wakes it.
// R24 - Smart receive is suspended during any CCA or energy scan.
// R25 - One power-save output covers all enabled saving conditions; synth saving drives its own o_synth_saving output instead.
//
// Implementation choice: the address-and-strobe port.
`include "rpc_map.svh"
module rpc_ctrl #(
    parameter int CAL_CYCLES = (`RPC_CAL_NS * `RPC_CLK_MHZ + 999) / 1000
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Register port
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // Radio state machine
    input wire rpc_pkg::rpc_radio_t i_radio,
    input wire rpc_pkg::rpc_act_t i_act,
    input wire rpc_pkg::rpc_frame_t i_frame,
    // Control to the radio
    output logic o_power_save,
    output logic o_abort_relisten,
    output logic o_desense_on,
    output logic o_deep_desense,
    output logic o_smart_rx_on,
    output logic [1:0] o_smart_rx_level,
    output logic o_synth_saving,
    output logic [3:0] o_tx_power
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] xah;
        logic [3:0] txpwr_cfg;
        logic [3:0] txpwr_used;
        logic [3:0] threshold;
        logic [7:0] last_seq;
        logic seq_valid;
        logic [3:0] ack_pwr;
        logic retry_max;
        logic pam_sleep;
        logic [7:0] rdata;
        logic power_save;
        logic abort;
        logic desense;
        logic deep;
        logic smart;
        logic [3:0] tx_power;
    } rpc_state_t;
    rpc_state_t cur_ff;
    rpc_state_t nxt_s;

    logic synth_saving;
    logic [3:0] ack_choice;
    logic dup_seq;
    logic pam_active;
    logic in_rx;
    logic in_aack;
    logic in_aret;
    logic auto_pwr;

    assign in_aack = (i_radio == rpc_pkg::RPC_ST_AUTO_ACK_RECEIVE_STATE);
    assign in_rx = (i_radio == rpc_pkg::RPC_ST_RX) || in_aack;
    assign in_aret = (i_radio == rpc_pkg::RPC_ST_ARET);
    assign auto_pwr = cur_ff.ctrl[`RPC_BIT_AUTOPWR]; // R20
    assign dup_seq = cur_ff.seq_valid && (i_frame.seq == cur_ff.last_seq); // R06
    // Promiscuous overrides the enable; ack time and reserved type filter bits must both be set
    assign pam_active = cur_ff.ctrl[`RPC_BIT_PANMATCH] && in_aack // R21
        && cur_ff.xah[`RPC_BIT_ACKTIME] && cur_ff.xah[`RPC_BIT_RESFT] // R10
        && !cur_ff.xah[`RPC_BIT_PROM]; // R11

    // Synthesizer saving in synth-on and retry-on states
    rpc_synth_save #(
        .CAL_CYCLES(CAL_CYCLES)
    ) u_synth (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_enable(cur_ff.ctrl[`RPC_BIT_SYNTH]), // R19
        .i_enter((i_radio == rpc_pkg::RPC_ST_SYNTH_ON) || (i_radio == rpc_pkg::RPC_ST_ARET_ON)),
        .i_wake(i_act.synth_wake),
        .o_saving(synth_saving)
    );

    // Ack power from the frame just received
    rpc_ack_power u_ackpwr (
        .i_ed_dbm(i_frame.ed_dbm),
        .i_lqi(i_frame.lqi),
        .i_dup_seq(dup_seq),
        .i_enable(auto_pwr && in_aack),
        .i_ceiling(cur_ff.txpwr_cfg),
        .o_power(ack_choice)
    );

    // Register file, power bookkeeping and saving decisions
    always_comb begin
        nxt_s = cur_ff;
        nxt_s.abort = 1'b0;
        // Writes; reserved bit 0 stored as written, host keeps it at one
        if (i_wr) begin
            case (i_addr)
                `RPC_ADDR_CTRL: nxt_s.ctrl = i_wdata; // R16 R17 R18 R22
                `RPC_ADDR_XAH: nxt_s.xah = i_wdata;
                `RPC_ADDR_TXPWR: nxt_s.txpwr_cfg = i_wdata[3:0];
                `RPC_ADDR_SYN: nxt_s.threshold = i_wdata[3:0];
                default: ;
            endcase
        end
        // Frame report: latch ack power before sequence number updates
        if (i_frame.valid) begin
            nxt_s.ack_pwr = ack_choice; // R03
            nxt_s.last_seq = i_frame.seq;
            nxt_s.seq_valid = 1'b1;
            if (pam_active && i_act.pan_fail) begin
                nxt_s.abort = 1'b1; // R08
            end else if (pam_active && i_act.addr_fail) begin
                nxt_s.pam_sleep = 1'b1; // R09
            end
        end
        // Sleep lasts to frame end, or through the ack period if requested
        if (cur_ff.pam_sleep && i_act.frame_end && !i_act.ack_req) begin
            nxt_s.pam_sleep = 1'b0;
        end
        if (!in_aack) begin
            nxt_s.pam_sleep = 1'b0;
        end
        // Retry escalation to full power after a reduced first attempt
        if (i_act.aret_start) begin
            nxt_s.retry_max = 1'b0;
        end
        if (in_aret && auto_pwr && i_act.tx_fail && cur_ff.txpwr_cfg != `RPC_PWR_MAX) begin
            nxt_s.retry_max = 1'b1; // R07
        end
        // Power used for this transmission, visible on readback
        nxt_s.tx_power = in_aack ? cur_ff.ack_pwr :
            (cur_ff.retry_max ? `RPC_PWR_MAX : cur_ff.txpwr_cfg);
        if (i_act.tx_start) begin
            nxt_s.txpwr_used = nxt_s.tx_power; // R05
        end else if (i_wr && i_addr == `RPC_ADDR_TXPWR) begin
            nxt_s.txpwr_used = i_wdata[3:0];
        end
        // Read data one cycle after the strobe; unmapped reads zero
        nxt_s.rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                `RPC_ADDR_CTRL: nxt_s.rdata = cur_ff.ctrl;
                `RPC_ADDR_XAH: nxt_s.rdata = cur_ff.xah;
                `RPC_ADDR_TXPWR: nxt_s.rdata = {4'h0, cur_ff.txpwr_used}; // R05
                `RPC_ADDR_SYN: nxt_s.rdata = {4'h0, cur_ff.threshold};
                default: nxt_s.rdata = 8'h00;
            endcase
        end
        // Desense and smart receive, both off during scans
        nxt_s.desense = cur_ff.ctrl[`RPC_BIT_DESENSE] && !i_act.cca_ed // R18 R02
            && (in_rx || in_aret);
        // Deep listen only with the special threshold; trades sensitivity for current
        nxt_s.deep = nxt_s.desense && (cur_ff.threshold == `RPC_THR_LEVEL); // R01
        nxt_s.smart = cur_ff.ctrl[`RPC_BIT_SMART] && !i_act.cca_ed // R17 R24
            && (in_rx || in_aret);
        // Single power-save request; released when activity resumes
        nxt_s.power_save = !i_act.tx_start && !i_act.cca_ed && (
            (in_rx && i_act.buf_protect) || // R12
            (in_aret && i_act.backoff) || // R13
            (in_aret && i_act.ack_wait) || // R14
            (in_aack && i_act.ack_pending) || // R14
            nxt_s.pam_sleep); // R25
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cur_ff <= '0;
            cur_ff.ctrl <= `RPC_RESET_CTRL; // R16 R22
            cur_ff.xah <= `RPC_RESET_XAH;
            cur_ff.txpwr_cfg <= `RPC_RESET_TXPWR;
            cur_ff.txpwr_used <= `RPC_RESET_TXPWR;
            cur_ff.threshold <= `RPC_RESET_THR;
            cur_ff.tx_power <= `RPC_RESET_TXPWR;
        end else begin
            cur_ff <= nxt_s;
        end
    end

    // Outputs straight from flip-flops
    assign o_rdata = cur_ff.rdata;
    assign o_power_save = cur_ff.power_save;
    assign o_abort_relisten = cur_ff.abort;
    // Threshold 0x08 with desense gives the deep -80 dBm listen mode
    assign o_desense_on = cur_ff.desense;
    assign o_deep_desense = cur_ff.deep; // R01
    assign o_smart_rx_on = cur_ff.smart;
    assign o_smart_rx_level = cur_ff.ctrl[`RPC_BIT_LEVEL_HI:`RPC_BIT_LEVEL_LO]; // R16
    assign o_synth_saving = synth_saving;
    assign o_tx_power = cur_ff.tx_power;

    // Scans always suspend desense and smart receive
    sequence scan_s;
        i_act.cca_ed;
    endsequence
    scan_desense_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        scan_s |=> !o_desense_on) else $error("desense active during scan"); // R02
    scan_smart_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        scan_s |=> !o_smart_rx_on) else $error("smart receive during scan"); // R24
    buf_sleep_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (in_rx && i_act.buf_protect && !i_act.cca_ed && !i_act.tx_start) |=> o_power_save)
        else $error("no sleep during buffer protection"); // R12
    backoff_sleep_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (in_aret && i_act.backoff && !i_act.cca_ed && !i_act.tx_start) |=> o_power_save)
        else $error("no sleep during backoff"); // R13
    ackwait_sleep_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (in_aret && i_act.ack_wait && !i_act.cca_ed && !i_act.tx_start) |=> o_power_save)
        else $error("no sleep awaiting ack"); // R14
    prom_nopam_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        cur_ff.xah[`RPC_BIT_PROM] |=> !o_abort_relisten)
        else $error("PAN abort in promiscuous mode"); // R11
    pan_abort_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (pam_active && i_frame.valid && i_act.pan_fail) |=> o_abort_relisten)
        else $error("PAN mismatch not aborted"); // R08
    retry_max_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (in_aret && auto_pwr && i_act.tx_fail && !i_act.aret_start
            && cur_ff.txpwr_cfg != `RPC_PWR_MAX) ##1 in_aret |=> o_tx_power == `RPC_PWR_MAX)
        else $error("retry not at full power"); // R07
    readback_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_act.tx_start && !in_aack) ##1 (i_rd && i_addr == `RPC_ADDR_TXPWR && !i_wr)
            |=> o_rdata[3:0] == $past(o_tx_power, 1))
        else $error("power readback wrong"); // R05
endmodule // rpc_ctrl

/* File: rtl/rpc_map.svh */
`ifndef RPC_MAP_SVH
`define RPC_MAP_SVH
// Register offsets (8-bit address space)
`define RPC_ADDR_CTRL 8'h16
`define RPC_ADDR_TXPWR 8'h05
`define RPC_ADDR_SYN 8'h15
`define RPC_ADDR_XAH 8'h17
// Reduced-power control fields
`define RPC_BIT_LEVEL_HI 7
`define RPC_BIT_LEVEL_LO 6
`define RPC_BIT_SMART 5
`define RPC_BIT_DESENSE 4
`define RPC_BIT_SYNTH 3
`define RPC_BIT_AUTOPWR 2
`define RPC_BIT_PANMATCH 1
`define RPC_BIT_RSVD 0
`define RPC_RESET_CTRL 8'hC1
// Auxiliary control register fields
`define RPC_BIT_ACKTIME 0
`define RPC_BIT_RESFT 1
`define RPC_BIT_PROM 2
`define RPC_RESET_XAH 8'h00
`define RPC_RESET_TXPWR 4'h0
`define RPC_RESET_THR 4'h0
// Thresholds: energy in dBm (signed), link quality
`define RPC_THR_LEVEL 4'h8
`define RPC_ED_REDUCE (-77)
`define RPC_ED_FLOOR (-45)
`define RPC_LQI_MIN 8'hE0
// Power codes: 0 is +4 dBm, 4'hF is -17 dBm
`define RPC_PWR_MAX 4'h0
`define RPC_PWR_MIN 4'hF
`define RPC_PWR_MID 4'h8
// Synthesizer calibration run length
`define RPC_CAL_NS 1000
`define RPC_CLK_MHZ 200
`endif

/* File: rtl/rpc_pkg.sv */
package rpc_pkg;
    // Radio state seen from the state machine
    typedef enum logic [2:0] {
        RPC_ST_OFF = 3'h0,
        RPC_ST_RX = 3'h1,
        RPC_ST_AUTO_ACK_RECEIVE_STATE = 3'h3,
        RPC_ST_SYNTH_ON = 3'h2,
        RPC_ST_ARET_ON = 3'h6,
        RPC_ST_ARET = 3'h7
    } rpc_radio_t;
    // Synthesizer saving sequence, Gray coded
    typedef enum logic [1:0] {
        RPC_SY_IDLE = 2'h0,
        RPC_SY_CAL = 2'h1,
        RPC_SY_SAVE = 2'h3,
        RPC_SY_AWAKE = 2'h2
    } rpc_synth_t;
    // Received frame report
    typedef struct packed {
        logic valid;
        logic signed [7:0] ed_dbm;
        logic [7:0] lqi;
        logic [7:0] seq;
    } rpc_frame_t;
    // Register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rpc_bus_t;
    // Activity indications from the radio
    typedef struct packed {
        logic cca_ed;
        logic buf_protect;
        logic backoff;
        logic ack_wait;
        logic ack_pending;
        logic pan_fail;
        logic addr_fail;
        logic ack_req;
        logic frame_end;
        logic synth_wake;
        logic tx_start;
        logic tx_fail;
        logic aret_start;
    } rpc_act_t;
endpackage

/* File: rtl/rpc_synth_save.sv */
// Synthesizer saving sequencer: calibrate on entry, then save, wake on demand
`include "rpc_map.svh"
module rpc_synth_save #(
    parameter int CAL_CYCLES = (`RPC_CAL_NS * `RPC_CLK_MHZ + 999) / 1000
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Control
    input wire logic i_enable,
    input wire logic i_enter,
    input wire logic i_wake,
    // Status
    output logic o_saving
);
    typedef struct packed {
        rpc_pkg::rpc_synth_t st;
        logic [15:0] cnt;
        logic saving;
    } rpc_sy_state_t;
    rpc_sy_state_t cur_ff;
    rpc_sy_state_t nxt_s;

    // Calibration then saving; wake requests leave saving until they end
    always_comb begin
        nxt_s = cur_ff;
        case (cur_ff.st)
            rpc_pkg::RPC_SY_IDLE: begin
                if (i_enable && i_enter) begin
                    nxt_s.st = rpc_pkg::RPC_SY_CAL; // R23
                    nxt_s.cnt = 16'(CAL_CYCLES - 1);
                end
            end
            rpc_pkg::RPC_SY_CAL: begin
                if (cur_ff.cnt == 16'h0000) begin
                    nxt_s.st = rpc_pkg::RPC_SY_SAVE;
                end else begin
                    nxt_s.cnt = cur_ff.cnt - 16'h0001;
                end
            end
            rpc_pkg::RPC_SY_SAVE: begin
                if (i_wake) begin
                    nxt_s.st = rpc_pkg::RPC_SY_AWAKE; // R23
                end
            end
            rpc_pkg::RPC_SY_AWAKE: begin
                if (!i_wake) begin
                    nxt_s.st = rpc_pkg::RPC_SY_SAVE;
                end
            end
            default: nxt_s.st = rpc_pkg::RPC_SY_IDLE;
        endcase
        // Disable or leaving the saving states drops everything
        if (!i_enable || !i_enter) begin
            nxt_s.st = rpc_pkg::RPC_SY_IDLE;
        end
        nxt_s.saving = (nxt_s.st == rpc_pkg::RPC_SY_SAVE);
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_s;
        end
    end

    assign o_saving = cur_ff.saving;

    calib_then_save_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(cur_ff.st == rpc_pkg::RPC_SY_SAVE) |-> $past(cur_ff.st) != rpc_pkg::RPC_SY_IDLE)
        else $error("saving entered without calibration"); // R23
endmodule // rpc_synth_save
